// [logic/piu_pkg.sv]
package piu_pkg;
  // ---------------------------------------------------------------
  // sources, in priority order (index 0 highest after reset)
  // ---------------------------------------------------------------
  localparam int NSRC = 11;
  localparam int SRC_PWD = 0;
  localparam int SRC_EXT2 = 1;
  localparam int SRC_LVL1 = 2;
  localparam int SRC_LVL0 = 3;
  localparam int SRC_S0TX = 4;
  localparam int SRC_S0RX = 5;
  localparam int SRC_EDGE = 6;
  localparam int SRC_BYTE_DMA_PORT = 7;
  localparam int SRC_S1TX = 8;
  localparam int SRC_S1RX = 9;
  localparam int SRC_TMR = 10;
  localparam int IDX_W = 4;
  localparam logic [IDX_W-1:0] IDX_NONE = 4'hF;
  // ---------------------------------------------------------------
  // vectors
  // ---------------------------------------------------------------
  localparam int VEC_W = 14;
  localparam logic [VEC_W-1:0] VEC_RESET = 14'h0000;
  localparam logic [VEC_W-1:0] VEC_PWD = 14'h002C;
  localparam logic [VEC_W-1:0] VEC_EXT2 = 14'h0004;
  localparam logic [VEC_W-1:0] VEC_LVL1 = 14'h0008;
  localparam logic [VEC_W-1:0] VEC_LVL0 = 14'h000C;
  localparam logic [VEC_W-1:0] VEC_S0TX = 14'h0010;
  localparam logic [VEC_W-1:0] VEC_S0RX = 14'h0014;
  localparam logic [VEC_W-1:0] VEC_EDGE = 14'h0018;
  localparam logic [VEC_W-1:0] VEC_BYTE_DMA_PORT = 14'h001C;
  localparam logic [VEC_W-1:0] VEC_S1TX = 14'h0020;
  localparam logic [VEC_W-1:0] VEC_S1RX = 14'h0024;
  localparam logic [VEC_W-1:0] VEC_TMR = 14'h0028;
  // ---------------------------------------------------------------
  // wishbone register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int ADR_W = 4;
  localparam logic [ADR_W-1:0] ADR_MASK = 4'h0;
  localparam logic [ADR_W-1:0] ADR_CTRL = 4'h4;
  localparam logic [ADR_W-1:0] ADR_FORCE_CLEAR = 4'h8;
  localparam logic [ADR_W-1:0] ADR_STATUS = 4'hC;
  // control register fields
  localparam int CTL_SENSE0 = 0;
  localparam int CTL_SENSE1 = 1;
  localparam int CTL_SENSE2 = 2;
  localparam int CTL_NEST = 4;
  localparam int CTL_S1PIN = 5;
  localparam int CTL_CTXCLR = 6;
  localparam int CTL_W = 7;
  localparam logic [CTL_W-1:0] CTL_RESET = 7'h00;
  // force/clear register: force in 10:0, clear in 26:16, by source index
  localparam int FC_CLR_LSB = 16;
  // status register fields
  localparam int ST_PEND_LSB = 0;
  localparam int ST_GEN = 16;
  localparam int ST_DEPTH_LSB = 20;
  localparam int STACK_DEPTH = 12;
  localparam int DEPTH_W = 4;
  localparam logic [NSRC-1:0] MASK_RESET = 11'h000;

  typedef struct packed {
    logic [VEC_W-1:0] vector;
    logic valid;
  } piu_req_s;

  typedef struct packed {
    logic ack;
    logic rti;
    logic ena;
    logic dis;
    logic mask_wr;
  } piu_core_s;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_REQ = 2'b01,
    ST_HOLD = 2'b11
  } piu_state_e;
endpackage

// [logic/piu_prio.sv]
`timescale 1ns/10ps
module piu_prio (
  input wire logic [piu_pkg::NSRC-1:0] req_i,
  output logic [piu_pkg::IDX_W-1:0] idx_o,
  output logic hit_o
);
  import piu_pkg::*;
  // lowest index wins; loop from the bottom so the top overrides
  always_comb begin
    idx_o = IDX_NONE;
    hit_o = 1'b0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (req_i[i]) begin
        idx_o = IDX_W'(i);
        hit_o = 1'b1;
      end
    end
  end
endmodule // piu_prio

// [logic/piu_unit.sv]
`timescale 1ns/10ps
module piu_unit (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [piu_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_request_zero_i,
  input wire logic ext_request_one_i,
  input wire logic ext_request_two_i,
  input wire logic edge_request_pin_i,
  input wire logic level_request_zero_i,
  input wire logic level_request_one_i,
  input wire logic powerdown_i,
  input wire logic wake_i,
  input wire logic s0_tx_i,
  input wire logic s0_rx_i,
  input wire logic s1_tx_i,
  input wire logic s1_rx_i,
  input wire logic byte_dma_port_i,
  input wire logic timer_i,
  input wire piu_pkg::piu_core_s core_i,
  output piu_pkg::piu_req_s req_o,
  output logic [piu_pkg::DEPTH_W-1:0] depth_o,
  output logic irq_o
);
  import piu_pkg::*;

  function automatic logic [VEC_W-1:0] vec_of(input logic [IDX_W-1:0] idx);
    unique case (idx)
      4'h0: vec_of = VEC_PWD;
      4'h1: vec_of = VEC_EXT2;
      4'h2: vec_of = VEC_LVL1;
      4'h3: vec_of = VEC_LVL0;
      4'h4: vec_of = VEC_S0TX;
      4'h5: vec_of = VEC_S0RX;
      4'h6: vec_of = VEC_EDGE;
      4'h7: vec_of = VEC_BYTE_DMA_PORT;
      4'h8: vec_of = VEC_S1TX;
      4'h9: vec_of = VEC_S1RX;
      4'hA: vec_of = VEC_TMR;
      default: vec_of = VEC_RESET;
    endcase
  endfunction

  function automatic logic [NSRC-1:0] onehot(input logic [IDX_W-1:0] idx);
    onehot = (idx < IDX_W'(NSRC)) ? NSRC'(1) << idx : '0;
  endfunction

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int NPIN = 7;
  logic [NPIN-1:0] pin_raw, pin_s1_q, pin_s2_q, pin_s3_q;
  assign pin_raw = {wake_i, powerdown_i, level_request_one_i, level_request_zero_i,
                    edge_request_pin_i, ext_request_one_i, ext_request_two_i};
  logic ext0_s1_q, ext0_s2_q, ext0_s3_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1_q <= '0;
      pin_s2_q <= '0;
      pin_s3_q <= '0;
      ext0_s1_q <= 1'b0;
      ext0_s2_q <= 1'b0;
      ext0_s3_q <= 1'b0;
    end else if (ce_i) begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      ext0_s1_q <= ext_request_zero_i;
      ext0_s2_q <= ext0_s1_q;
      ext0_s3_q <= ext0_s2_q;
    end
  end

  logic [NPIN-1:0] pin_rise;
  assign pin_rise = pin_s2_q & ~pin_s3_q;
  logic ext0_rise;
  assign ext0_rise = ext0_s2_q & ~ext0_s3_q;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [NSRC-1:0] mask_q;
  logic [CTL_W-1:0] ctl_q;
  logic gen_q;
  logic blk_q;
  logic [NSRC-1:0] pend_q;
  logic wb_hit, wr_en;
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = wb_hit && wb_we_i && ce_i;
  logic wr_mask, wr_ctl, wr_fc;
  assign wr_mask = wr_en && wb_adr_i == ADR_MASK && wb_sel_i[0] && wb_sel_i[1];
  assign wr_ctl = wr_en && wb_adr_i == ADR_CTRL && wb_sel_i[0];
  assign wr_fc = wr_en && wb_adr_i == ADR_FORCE_CLEAR;
  logic mask_mod;
  assign mask_mod = wr_mask || core_i.mask_wr;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_q <= MASK_RESET;
    end else if (ce_i && wr_mask) begin
      mask_q <= wb_dat_i[NSRC-1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_q <= CTL_RESET;
    end else if (ce_i && wr_ctl) begin
      ctl_q <= wb_dat_i[CTL_W-1:0];
    end
  end

  // mask change blocks selection in its own cycle and the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      blk_q <= 1'b0;
    end else if (ce_i) begin
      blk_q <= mask_mod;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      gen_q <= 1'b1;
    end else if (ce_i) begin
      if (core_i.dis) begin
        gen_q <= 1'b0;
      end else if (core_i.ena) begin
        gen_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // request sensing
  // ---------------------------------------------------------------
  logic s1pin;
  assign s1pin = ctl_q[CTL_S1PIN];
  logic e0_lvl, e1_lvl, e2_lvl, e0_edg, e1_edg, e2_edg;
  assign e2_lvl = !ctl_q[CTL_SENSE2] && pin_s2_q[0];
  assign e1_lvl = !ctl_q[CTL_SENSE1] && pin_s2_q[1];
  assign e0_lvl = !ctl_q[CTL_SENSE0] && ext0_s2_q;
  assign e2_edg = ctl_q[CTL_SENSE2] && pin_rise[0];
  assign e1_edg = ctl_q[CTL_SENSE1] && pin_rise[1];
  assign e0_edg = ctl_q[CTL_SENSE0] && ext0_rise;

  // edge events that latch; serial pulses latch too
  logic [NSRC-1:0] set_ev;
  always_comb begin
    set_ev = '0;
    set_ev[SRC_PWD] = pin_rise[5];
    set_ev[SRC_EXT2] = e2_edg;
    set_ev[SRC_S0TX] = s0_tx_i;
    set_ev[SRC_S0RX] = s0_rx_i;
    set_ev[SRC_EDGE] = pin_rise[2];
    set_ev[SRC_BYTE_DMA_PORT] = byte_dma_port_i;
    set_ev[SRC_S1TX] = s1pin ? e1_edg : s1_tx_i;
    set_ev[SRC_S1RX] = s1pin ? e0_edg : s1_rx_i;
    set_ev[SRC_TMR] = timer_i;
  end

  // level requests are never latched
  logic [NSRC-1:0] lvl_req;
  always_comb begin
    lvl_req = '0;
    lvl_req[SRC_EXT2] = e2_lvl;
    lvl_req[SRC_LVL1] = pin_s2_q[4];
    lvl_req[SRC_LVL0] = pin_s2_q[3];
    lvl_req[SRC_S1TX] = s1pin && e1_lvl;
    lvl_req[SRC_S1RX] = s1pin && e0_lvl;
  end

  logic [NSRC-1:0] fc_force, fc_clear, ack_clr;
  assign fc_force = wr_fc ? wb_dat_i[NSRC-1:0] : '0;
  assign fc_clear = wr_fc ? wb_dat_i[FC_CLR_LSB +: NSRC] : '0;

  logic [IDX_W-1:0] cur_idx_q;
  assign ack_clr = core_i.ack ? onehot(cur_idx_q) : '0;

  // set wins over any clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_q <= '0;
    end else if (ce_i) begin
      pend_q <= (pend_q & ~fc_clear & ~ack_clr) | set_ev | fc_force;
    end
  end

  // ---------------------------------------------------------------
  // selection
  // ---------------------------------------------------------------
  logic [NSRC-1:0] active, eligible;
  logic [IDX_W-1:0] win_idx;
  logic win_hit;
  always_comb begin
    active = pend_q | lvl_req;
    eligible = active & mask_q;
    eligible[SRC_PWD] = active[SRC_PWD];
  end

  piu_prio u_prio (
    .req_i(eligible),
    .idx_o(win_idx),
    .hit_o(win_hit)
  );

  // ---------------------------------------------------------------
  // nesting stack of running handlers
  // ---------------------------------------------------------------
  logic [IDX_W-1:0] stk_q [STACK_DEPTH];
  logic [DEPTH_W-1:0] depth_q;
  logic [IDX_W-1:0] run_idx;
  assign run_idx = (depth_q == '0) ? IDX_NONE : stk_q[depth_q - DEPTH_W'(1)];
  logic can_take;
  always_comb begin
    if (!gen_q || blk_q || mask_mod || !win_hit) begin
      can_take = 1'b0;
    end else if (depth_q == '0) begin
      can_take = 1'b1;
    end else if (depth_q == DEPTH_W'(STACK_DEPTH)) begin
      can_take = 1'b0;
    end else begin
      can_take = ctl_q[CTL_NEST] && win_idx < run_idx;
    end
  end

  piu_state_e st_q;
  logic wake_ctx;
  assign wake_ctx = pin_rise[6] && ctl_q[CTL_CTXCLR];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q <= ST_RUN;
      cur_idx_q <= IDX_NONE;
      req_o <= '{vector: VEC_RESET, valid: 1'b1};
    end else if (ce_i) begin
      unique case (st_q)
        ST_RUN: begin
          if (wake_ctx) begin
            req_o <= '{vector: VEC_RESET, valid: 1'b1};
            cur_idx_q <= IDX_NONE;
            st_q <= ST_REQ;
          end else if (req_o.valid) begin
            // reset vector still outstanding: nothing may displace it
            if (core_i.ack) begin
              req_o.valid <= 1'b0;
            end
          end else if (can_take) begin
            req_o <= '{vector: vec_of(win_idx), valid: 1'b1};
            cur_idx_q <= win_idx;
            st_q <= ST_REQ;
          end
        end
        ST_REQ: begin
          if (core_i.ack) begin
            req_o.valid <= 1'b0;
            st_q <= ST_HOLD;
          end
        end
        ST_HOLD: st_q <= ST_RUN;
      endcase
    end
  end

  // push on entry, pop on return
  always_ff @(posedge clk_i) begin
    if (rst_i || (ce_i && wake_ctx && st_q == ST_RUN)) begin
      depth_q <= '0;
    end else if (ce_i) begin
      if (st_q == ST_REQ && core_i.ack && cur_idx_q != IDX_NONE) begin
        stk_q[depth_q] <= cur_idx_q;
        depth_q <= depth_q + DEPTH_W'(1);
      end else if (core_i.rti && depth_q != '0) begin
        depth_q <= depth_q - DEPTH_W'(1);
      end
    end
  end
  assign depth_o = depth_q;
  assign irq_o = req_o.valid;

  // ---------------------------------------------------------------
  // wishbone read path and ack for every transfer; writes are decoded above
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else if (ce_i) begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= '0;
      if (wb_hit && !wb_we_i) begin
        unique case (wb_adr_i)
          ADR_MASK: wb_dat_o[NSRC-1:0] <= mask_q;
          ADR_CTRL: wb_dat_o[CTL_W-1:0] <= ctl_q;
          ADR_STATUS: begin
            wb_dat_o[ST_PEND_LSB +: NSRC] <= active;
            wb_dat_o[ST_GEN] <= gen_q;
            wb_dat_o[ST_DEPTH_LSB +: DEPTH_W] <= depth_q;
          end
          default: wb_dat_o <= '0; // force/clear and unmapped read zero
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_pwd_vector: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && st_q == ST_RUN && can_take && win_idx == IDX_W'(SRC_PWD) && !wake_ctx && !req_o.valid
    |=> req_o.vector == VEC_PWD) else $error("power-down vector wrong");
  a_mask_block: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && mask_mod |=> !can_take) else $error("interrupt taken after mask write");
  a_gen_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !gen_q |-> !can_take) else $error("interrupt taken while disabled");
  a_masked_out: assert property (@(posedge clk_i) disable iff (rst_i)
    win_hit && win_idx != IDX_W'(SRC_PWD) |-> mask_q[win_idx]) else $error("masked source selected");
  a_nest_off: assert property (@(posedge clk_i) disable iff (rst_i)
    !ctl_q[CTL_NEST] && depth_q != '0 |-> !can_take) else $error("nested without nesting mode");
  a_stack_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    depth_q <= DEPTH_W'(STACK_DEPTH)) else $error("stack overflow");
  a_edge_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && set_ev[SRC_EDGE] |=> pend_q[SRC_EDGE]) else $error("edge request lost");
  a_fc_read: assert property (@(posedge clk_i) disable iff (rst_i)
    ce_i && wb_hit && !wb_we_i && wb_adr_i == ADR_FORCE_CLEAR |=> wb_ack_o && wb_dat_o == '0)
    else $error("force/clear readable");
  a_reset_en: assert property (@(posedge clk_i) $fell(rst_i) |-> gen_q) else $error("not enabled after reset");
endmodule // piu_unit

// [sim/piu_core_model.sv]
`timescale 1ns/10ps
module piu_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire piu_pkg::piu_req_s req_i,
  input wire logic [3:0] delay_i,
  output logic ack_o,
  output logic [piu_pkg::VEC_W-1:0] vec_o,
  output logic [7:0] taken_o
);
  import piu_pkg::*;
  logic [3:0] wait_q;
  logic busy_q;
  // ----------------------------------------------------------
  // sequencer: takes a vector after delay_i cycles of valid
  // ----------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      busy_q <= 1'b0;
      wait_q <= 4'h0;
      taken_o <= 8'h00;
      vec_o <= '0;
    end else begin
      ack_o <= 1'b0;
      if (ack_o) begin
        vec_o <= req_i.vector;
        taken_o <= taken_o + 8'h01;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        // valid lags ack by a cycle; never take one vector twice
        if (!req_i.valid) begin
          busy_q <= 1'b0;
        end
      end else if (req_i.valid) begin
        if (wait_q == delay_i) begin
          ack_o <= 1'b1;
          wait_q <= 4'h0;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule // piu_core_model

// [sim/tb_prioritized_interrupt_unit.sv]
`timescale 1ns/10ps
module tb_prioritized_interrupt_unit;
  import piu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_q = 1'b0;
  logic we_q = 1'b0;
  logic [3:0] adr_q = 4'h0;
  logic [31:0] dat_q = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [13:0] pin_q = 14'h0;
  logic [2:0] cs_q = 3'h0;
  logic mw_q = 1'b0;
  logic [3:0] delay_q = 4'h0;
  logic p_ack;
  logic [VEC_W-1:0] vec;
  logic [7:0] taken;
  logic [3:0] depth_o;
  logic irq_o;
  logic [31:0] rd;
  piu_core_s core_s;
  piu_req_s req_s;
  int n_fail = 0;
  int n_compared = 0;
  logic [VEC_W-1:0] row_vec [16] = '{VEC_PWD, VEC_EXT2, VEC_LVL1, VEC_LVL0, VEC_S0TX, VEC_S0RX, VEC_EDGE,
    VEC_BYTE_DMA_PORT, VEC_S1TX, VEC_S1RX, VEC_TMR, VEC_S1TX, VEC_S1RX, VEC_S1TX, VEC_S1RX, VEC_EXT2};
  logic [13:0] row_pin [16] = '{14'h0001, 14'h0002, 14'h0004, 14'h0008, 14'h0010, 14'h0020, 14'h0040,
    14'h0080, 14'h0100, 14'h0200, 14'h0400, 14'h0800, 14'h1000, 14'h0800, 14'h1000, 14'h0002};
  logic [7:0] row_ctl [16] = '{8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04, 8'h04,
    8'h04, 8'h27, 8'h27, 8'h20, 8'h20, 8'h00};
  // rows whose pin is held as a level rather than pulsed
  logic [15:0] row_lvl = 16'hE00C;
  always #20 clk_i = ~clk_i;
  // mw_q stands for the core's own mask-modify strobe
  assign core_s = {p_ack, cs_q, mw_q};
  piu_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc_q), .wb_stb_i(cyc_q),
    .wb_we_i(we_q), .wb_adr_i(adr_q), .wb_sel_i(4'hF), .wb_dat_i(dat_q), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .ext_request_zero_i(pin_q[12]), .ext_request_one_i(pin_q[11]),
    .ext_request_two_i(pin_q[1]), .edge_request_pin_i(pin_q[6]), .level_request_zero_i(pin_q[3]),
    .level_request_one_i(pin_q[2]), .powerdown_i(pin_q[0]), .wake_i(pin_q[13]), .s0_tx_i(pin_q[4]),
    .s0_rx_i(pin_q[5]), .s1_tx_i(pin_q[8]), .s1_rx_i(pin_q[9]), .byte_dma_port_i(pin_q[7]), .timer_i(pin_q[10]),
    .core_i(core_s), .req_o(req_s), .depth_o(depth_o), .irq_o(irq_o));
  piu_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_s), .delay_i(delay_q), .ack_o(p_ack),
    .vec_o(vec), .taken_o(taken));
  // ----------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    cyc_q <= 1'b1;
    we_q <= we;
    adr_q <= adr;
    dat_q <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    cyc_q <= 1'b0;
    we_q <= 1'b0;
  endtask
  task automatic pulse(input logic [13:0] m);
    @(posedge clk_i);
    pin_q <= m;
    @(posedge clk_i);
    pin_q <= 14'h0;
  endtask
  task automatic core(input logic [2:0] m);
    @(posedge clk_i);
    cs_q <= m;
    @(posedge clk_i);
    cs_q <= 3'h0;
  endtask
  task automatic take(input logic [VEC_W-1:0] v, input logic [3:0] d);
    logic [7:0] t0;
    int k;
    t0 = taken;
    k = 0;
    while (taken === t0 && k < 60) begin
      @(posedge clk_i);
      k++;
    end
    repeat (2) @(posedge clk_i);
    check(32'(k < 60), 32'h1);
    check(32'(vec), 32'(v));
    check(32'(depth_o), 32'(d));
  endtask
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge clk_i);
      check(32'(irq_o), 32'h0);
    end
  endtask
  task automatic ret();
    repeat (3) @(posedge clk_i);
    core(3'b100);
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    tally_and_finish();
  end
  // ----------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    take(VEC_RESET, 4'h0);
    wb(1'b0, ADR_STATUS, 32'h0);
    check(32'(rd[ST_GEN]), 32'h1);
    wb(1'b0, ADR_MASK, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 4'h6, 32'h0);
    check(rd, 32'h0);
    $display("reset test done");
    wb(1'b1, ADR_MASK, 32'h7FF);
    for (int i = 0; i < 16; i++) begin
      wb(1'b1, ADR_CTRL, 32'(row_ctl[i]));
      if (row_lvl[i]) begin
        @(posedge clk_i);
        pin_q <= row_pin[i];
        take(row_vec[i], 4'h1);
        pin_q <= 14'h0;
      end else begin
        pulse(row_pin[i]);
        take(row_vec[i], 4'h1);
      end
      ret();
      repeat (2) @(posedge clk_i);
      check(32'(depth_o), 32'h0);
    end
    $display("vector table done");
    wb(1'b1, ADR_CTRL, 32'h04);
    pulse(14'h0410);
    take(VEC_S0TX, 4'h1);
    ret();
    take(VEC_TMR, 4'h1);
    ret();
    wb(1'b1, ADR_MASK, 32'h77F);
    pulse(14'h0080);
    idle(10);
    wb(1'b1, ADR_MASK, 32'h000);
    pulse(14'h0001);
    take(VEC_PWD, 4'h1);
    ret();
    wb(1'b1, ADR_MASK, 32'h7FF);
    take(VEC_BYTE_DMA_PORT, 4'h1);
    ret();
    mw_q <= 1'b1;
    pulse(14'h0400);
    idle(6);
    mw_q <= 1'b0;
    take(VEC_TMR, 4'h1);
    ret();
    $display("mask test done");
    core(3'b001);
    wb(1'b0, ADR_STATUS, 32'h0);
    check(32'(rd[ST_GEN]), 32'h0);
    pulse(14'h0001);
    idle(10);
    core(3'b010);
    take(VEC_PWD, 4'h1);
    ret();
    $display("global enable test done");
    wb(1'b1, ADR_FORCE_CLEAR, 32'h40);
    take(VEC_EDGE, 4'h1);
    ret();
    wb(1'b0, ADR_FORCE_CLEAR, 32'h0);
    check(rd, 32'h0);
    core(3'b001);
    wb(1'b1, ADR_FORCE_CLEAR, 32'h400);
    wb(1'b1, ADR_FORCE_CLEAR, 32'h0400_0000);
    core(3'b010);
    idle(10);
    $display("force clear test done");
    pulse(14'h0400);
    take(VEC_TMR, 4'h1);
    pulse(14'h0010);
    idle(8);
    ret();
    take(VEC_S0TX, 4'h1);
    ret();
    delay_q <= 4'h3;
    wb(1'b1, ADR_CTRL, 32'h14);
    pulse(14'h0400);
    take(VEC_TMR, 4'h1);
    pulse(14'h0010);
    take(VEC_S0TX, 4'h2);
    pulse(14'h0080);
    idle(8);
    ret();
    take(VEC_BYTE_DMA_PORT, 4'h2);
    ret();
    ret();
    repeat (2) @(posedge clk_i);
    check(32'(depth_o), 32'h0);
    $display("nesting test done");
    wb(1'b1, ADR_CTRL, 32'h44);
    pulse(14'h2000);
    take(VEC_RESET, 4'h0);
    $display("wake test done");
    core(3'b001);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    take(VEC_RESET, 4'h0);
    wb(1'b0, ADR_MASK, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, ADR_STATUS, 32'h0);
    check(32'(rd[ST_GEN]), 32'h1);
    $display("mid-run reset test done");
    tally_and_finish();
  end
endmodule // tb_prioritized_interrupt_unit
